// *** logic/wdog_regs.svh ***
// register offsets, field positions, reset values and command codes
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH
`define OFS_COMMAND     8'h00
`define OFS_PRESCALER   8'h04
`define OFS_RELOAD      8'h08
`define OFS_STATUS      8'h0c
`define OFS_WINDOW      8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_MASK    8'h18
`define OFS_COUNTER     8'h1c
`define CMD_UNPROTECT   16'h5555
`define CMD_RELOAD      16'haaaa
`define CMD_START       16'hcccc
`define RST_RELOAD      12'h0fff
`define RST_WINDOW      12'h0fff
`define RST_PRESCALER   3'h0
`define BIT_PSC_BUSY    0
`define BIT_RLD_BUSY    1
`define BIT_WND_BUSY    2
`define BIT_EV_ZERO     0
`define BIT_EV_WINDOW   1
`define SYNC_CYCLES     3'h3
`define PSC_MAX_SEL     3'h6
`endif

// *** logic/wdog_pkg.sv ***
// types shared by the watchdog register block
package wdog_pkg;
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_BUSY
  } xfer_state_t;
endpackage

// *** logic/independent_watchdog.sv ***
// independent watchdog: command, prescaler, reload, window, status registers
//
// What this block does
// - reload command loads counter from reload value
// - reload register writable only when unprotected
// - status bit 1 busy during reload transfer
// - status bit 0 busy during prescaler transfer
// - status bit 2 busy during window transfer
// - reload above window value causes reset
// - window register writable only when unprotected
// - half or full word access, reserved zero
// - start command counts down, zero resets
// - any other command restores write protection
// - window change triggers a reload
// - eight-stage prescaler feeds 12-bit counter
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "wdog_regs.svh"
module independent_watchdog #(
  parameter int CNT_W = 12,
  parameter int PSC_W = 8
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_wd_tick,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_wdog_reset,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // tick synchroniser: slow watchdog clock arrives as a pin level
  logic       tick_s1_q;
  logic       tick_s2_q;
  logic       tick_s3_q;
  wire        tick_en = tick_s2_q & ~tick_s3_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= i_wd_tick;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire wr_cmd  = i_wr & (i_addr == `OFS_COMMAND);
  wire wr_psc  = i_wr & (i_addr == `OFS_PRESCALER);
  wire wr_rld  = i_wr & (i_addr == `OFS_RELOAD);
  wire wr_wnd  = i_wr & (i_addr == `OFS_WINDOW);
  wire wr_mask = i_wr & (i_addr == `OFS_IRQ_MASK);
  wire rd_irq  = i_rd & (i_addr == `OFS_IRQ_STATUS);
  wire [15:0] cmd = i_wdata[15:0];
  wire cmd_unprot = wr_cmd & (cmd == `CMD_UNPROTECT);
  wire cmd_reload = wr_cmd & (cmd == `CMD_RELOAD);
  wire cmd_start  = wr_cmd & (cmd == `CMD_START);

  ////////////////////////////////////////////////////////////////////////
  // write protection latch
  logic unlocked_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      unlocked_q <= 1'b0;
    end else if (wr_cmd) begin
      unlocked_q <= cmd_unprot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shadow registers seen by software, accepted only when unlocked
  logic [2:0]       psc_sw_q;
  logic [CNT_W-1:0] rld_sw_q;
  logic [CNT_W-1:0] wnd_sw_q;
  wire acc_psc = wr_psc & unlocked_q;
  wire acc_rld = wr_rld & unlocked_q;
  wire acc_wnd = wr_wnd & unlocked_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      psc_sw_q <= `RST_PRESCALER;
      rld_sw_q <= `RST_RELOAD;
      wnd_sw_q <= `RST_WINDOW;
    end else begin
      if (acc_psc) psc_sw_q <= i_wdata[2:0];
      if (acc_rld) rld_sw_q <= i_wdata[CNT_W-1:0];
      if (acc_wnd) wnd_sw_q <= i_wdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer into the watchdog time base, one engine per register
  logic [2:0]       busy;
  logic [2:0]       xfer_done;
  logic [2:0]       xfer_start;
  assign xfer_start = {acc_wnd, acc_rld, acc_psc};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_xfer
      wdog_pkg::xfer_state_t st_q;
      logic [2:0]            cnt_q;
      // busy spans a few slow ticks, like a real domain crossing
      always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
          st_q  <= wdog_pkg::XFER_IDLE;
          cnt_q <= 3'h0;
        end else begin
          case (st_q)
            wdog_pkg::XFER_IDLE: begin
              if (xfer_start[g]) begin
                st_q  <= wdog_pkg::XFER_BUSY;
                cnt_q <= `SYNC_CYCLES;
              end
            end
            wdog_pkg::XFER_BUSY: begin
              if (xfer_start[g]) begin
                cnt_q <= `SYNC_CYCLES;
              end else if (tick_en) begin
                if (cnt_q == 3'h1) begin
                  st_q <= wdog_pkg::XFER_IDLE;
                end
                cnt_q <= cnt_q - 3'h1;
              end
            end
            default: st_q <= wdog_pkg::XFER_IDLE;
          endcase
        end
      end
      assign busy[g] = (st_q == wdog_pkg::XFER_BUSY);
      assign xfer_done[g] = busy[g] & ~xfer_start[g] & tick_en
                            & (cnt_q == 3'h1);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // active copies used by the counter
  logic [2:0]       psc_act_q;
  logic [CNT_W-1:0] rld_act_q;
  logic [CNT_W-1:0] wnd_act_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      psc_act_q <= `RST_PRESCALER;
      rld_act_q <= `RST_RELOAD;
      wnd_act_q <= `RST_WINDOW;
    end else begin
      if (xfer_done[`BIT_PSC_BUSY]) psc_act_q <= psc_sw_q;
      if (xfer_done[`BIT_RLD_BUSY]) rld_act_q <= rld_sw_q;
      if (xfer_done[`BIT_WND_BUSY]) wnd_act_q <= wnd_sw_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and down counter
  logic             running_q;
  logic [PSC_W-1:0] psc_cnt_q;
  logic [CNT_W-1:0] count_q;
  logic             rst_q;
  wire  [2:0]  psc_sel = (psc_act_q > `PSC_MAX_SEL) ? `PSC_MAX_SEL
                                                     : psc_act_q;
  // divide by 4 << sel: terminal when low (sel+2) bits are all ones
  // shift amount kept four bits wide so that sel 6 does not wrap to zero
  wire  [3:0]       psc_sh   = {1'b0, psc_sel} + 4'h2;
  wire  [PSC_W-1:0] psc_mask = PSC_W'((1 << psc_sh) - 1);
  wire  psc_tc = tick_en & ((psc_cnt_q & psc_mask) == psc_mask);
  wire  wnd_reload = xfer_done[`BIT_WND_BUSY];
  wire  do_reload  = cmd_reload | wnd_reload;
  wire  win_fault  = cmd_reload & running_q & (count_q > wnd_act_q);
  wire  zero_fault = running_q & psc_tc & (count_q == '0);

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      running_q <= 1'b0;
      psc_cnt_q <= '0;
      count_q   <= `RST_RELOAD;
    end else begin
      if (cmd_start) running_q <= 1'b1;
      if (do_reload) begin
        count_q   <= rld_act_q;
        psc_cnt_q <= '0;
      end else if (running_q && tick_en) begin
        psc_cnt_q <= psc_cnt_q + 1'b1;
        if (psc_tc && count_q != '0) count_q <= count_q - 1'b1;
      end
    end
  end

  // reset request held until system reset removes it
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rst_q <= 1'b0;
    end else if (win_fault || zero_fault) begin
      rst_q <= 1'b1;
    end
  end
  assign o_wdog_reset = rst_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over read-clear
  logic [1:0] irq_st_q;
  logic [1:0] irq_mask_q;
  wire  [1:0] irq_set;
  assign irq_set[`BIT_EV_ZERO]   = zero_fault;
  assign irq_set[`BIT_EV_WINDOW] = win_fault;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      irq_st_q   <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      irq_st_q <= (rd_irq ? 2'h0 : irq_st_q) | irq_set;
      if (wr_mask) irq_mask_q <= i_wdata[1:0];
    end
  end
  assign o_irq = |(irq_st_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // read mux: narrow fields sit low, reserved bits zero
  logic [31:0] rmux;
  always_comb begin
    case (i_addr)
      `OFS_PRESCALER:  rmux = {29'h0, psc_sw_q};
      `OFS_RELOAD:     rmux = {20'h0, rld_sw_q};
      `OFS_STATUS:     rmux = {29'h0, busy};
      `OFS_WINDOW:     rmux = {20'h0, wnd_sw_q};
      `OFS_IRQ_STATUS: rmux = {30'h0, irq_st_q};
      `OFS_IRQ_MASK:   rmux = {30'h0, irq_mask_q};
      `OFS_COUNTER:    rmux = {19'h0, running_q, count_q};
      default:         rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rmux;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

// *** test/wdog_regs_sva.sv ***
// assertion checker for the watchdog register block
`timescale 1ns/1ps
`include "wdog_regs.svh"
module wdog_regs_chk (
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        i_wd_tick,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_wdog_reset,
  input wire logic        o_irq
);
  logic unlocked_q;
  logic unlocked_d;
  logic cmd_wr;
  // mirror of the write-protection state
  assign cmd_wr = i_wr && (i_addr == `OFS_COMMAND);
  assign unlocked_d = cmd_wr ? (i_wdata[15:0] == `CMD_UNPROTECT) : unlocked_q;
  always_ff @(posedge i_clock) begin
    unlocked_q <= i_rst_b ? unlocked_d : 1'b0;
  end
  ////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_rst_hold;
    o_wdog_reset |=> o_wdog_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("watchdog reset dropped");
  property p_rst_clr;
    !$past(i_rst_b) |-> !o_wdog_reset;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("watchdog reset survives reset");
  property p_rsv(logic [7:0] a, int hi);
    $past(i_rd) && $past(i_addr) == a |-> (o_rdata >> hi) == 32'h0000_0000;
  endproperty
  a_stat_rsv: assert property (p_rsv(`OFS_STATUS, 3))
    else $error("status reserved bits set");
  a_rld_rsv: assert property (p_rsv(`OFS_RELOAD, 12))
    else $error("reload reserved bits set");
  a_wnd_rsv: assert property (p_rsv(`OFS_WINDOW, 12))
    else $error("window reserved bits set");
  property p_busy(logic [7:0] a, int b);
    i_wr && i_addr == a && unlocked_q ##1 i_rd && i_addr == `OFS_STATUS
      |=> o_rdata[b];
  endproperty
  a_rld_busy: assert property (p_busy(`OFS_RELOAD, 1))
    else $error("reload busy not shown");
  a_psc_busy: assert property (p_busy(`OFS_PRESCALER, 0))
    else $error("prescaler busy not shown");
  a_wnd_busy: assert property (p_busy(`OFS_WINDOW, 2))
    else $error("window busy not shown");
  c_rst: cover property ($rose(o_wdog_reset));
  c_irq: cover property ($rose(o_irq));
  c_busy: cover property (p_busy(`OFS_RELOAD, 1));
endmodule
bind independent_watchdog wdog_regs_chk chk_u (.i_clock(i_clock),
  .i_rst_b(i_rst_b), .i_wd_tick(i_wd_tick), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_wdog_reset(o_wdog_reset), .o_irq(o_irq));

// *** test/tb_top.sv ***
// self-checking bench for the watchdog register block
`timescale 1ns/1ps
`include "wdog_regs.svh"
module tb_top;
  logic        i_clock = 0;
  logic        i_rst_b = 0;
  logic        tick_en = 0;
  logic [2:0]  div_q = 0;
  logic [7:0]  i_addr = 0;
  logic [31:0] i_wdata = 0;
  logic        i_wr = 0;
  logic        i_rd = 0;
  logic [31:0] o_rdata;
  logic        o_wdog_reset;
  logic        o_irq;
  int          n_errors = 0;
  int          cmp_count = 0;
  wire logic   i_wd_tick = tick_en & div_q[2];
  // system clock and a slow tick at one eighth of it
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) div_q <= div_q + 3'h1;
  independent_watchdog dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_wd_tick(i_wd_tick), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_wdog_reset(o_wdog_reset), .o_irq(o_irq));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one bus cycle, driven right after a rising edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 check(exp, o_rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
  endtask
  // poll status until every update has crossed, bounded
  task automatic wait_idle();
    for (int k = 0; k < 200; k++) begin
      bus(1'b0, 1'b1, `OFS_STATUS, 32'h0000_0000);
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      if (o_rdata[2:0] === 3'h0) break;
    end
    check(32'h0000_0000, {29'h0, o_rdata[2:0]});
  endtask
  task automatic do_reset();
    i_rst_b <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    #400_000;
    n_errors++;
    test_done();
  end
  ////////////////////////////////////////
  initial begin
    do_reset();
    rd(`OFS_RELOAD, 32'h0000_0fff);
    rd(`OFS_WINDOW, 32'h0000_0fff);
    rd(`OFS_STATUS, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(`OFS_RELOAD, 32'h0000_0123);
    rd(`OFS_RELOAD, 32'h0000_0fff);
    wr(`OFS_COMMAND, 32'h0000_5555);
    wr(`OFS_RELOAD, 32'hffff_f123);
    rd(`OFS_STATUS, 32'h0000_0002);
    wr(`OFS_STATUS, 32'h0000_0000);
    rd(`OFS_RELOAD, 32'h0000_0123);
    wr(`OFS_PRESCALER, 32'h0000_0000);
    rd(`OFS_STATUS, 32'h0000_0003);
    wr(`OFS_WINDOW, 32'h0000_0fff);
    rd(`OFS_STATUS, 32'h0000_0007);
    tick_en <= 1'b1;
    wait_idle();
    wr(`OFS_COMMAND, 32'h0000_0000);
    wr(`OFS_WINDOW, 32'h0000_0010);
    rd(`OFS_WINDOW, 32'h0000_0fff);
    wr(`OFS_COMMAND, 32'h0000_cccc);
    wr(`OFS_COMMAND, 32'h0000_aaaa);
    wr(`OFS_IRQ_MASK, 32'h0000_0003);
    idle(100);
    check(32'h0000_0000, {31'h0, o_wdog_reset});
    wr(`OFS_COMMAND, 32'h0000_5555);
    wr(`OFS_WINDOW, 32'h0000_0100);
    wait_idle();
    wr(`OFS_COMMAND, 32'h0000_aaaa);
    idle(100);
    check(32'h0000_0001, {31'h0, o_wdog_reset});
    check(32'h0000_0001, {31'h0, o_irq});
    rd(`OFS_IRQ_STATUS, 32'h0000_0002);
    idle(1);
    check(32'h0000_0000, {31'h0, o_irq});
    do_reset();
    wr(`OFS_COMMAND, 32'h0000_5555);
    wr(`OFS_RELOAD, 32'h0000_0002);
    wait_idle();
    wr(`OFS_COMMAND, 32'h0000_cccc);
    wr(`OFS_COMMAND, 32'h0000_aaaa);
    idle(300);
    check(32'h0000_0001, {31'h0, o_wdog_reset});
    check(32'h0000_0000, {31'h0, o_irq});
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    idle(2);
    check(32'h0000_0001, {31'h0, o_irq});
    rd(`OFS_IRQ_STATUS, 32'h0000_0001);
    wait_idle();
    test_done();
  end
endmodule
